/* logic/sff_pkg.sv */
// Constants shared by the synchronous FIFO bank and its helpers.
// Assumes one clock domain for writer, reader and flag logic.
//
// Functional notes
// - Reset-time straps choose standard or fall-through
// - Standard mode: output changes only on reads
// - Read: enable low at rising edge
// - Fall-through: first word shown after three edges
// - Write: enable low captures input each edge
// - Standard empty flag rises on first word
// - Almost-empty rises at n plus one words
// - Half-full falls at half depth plus one
// - Almost-full falls at depth minus m words
// - Full at depth words; writes then ignored
// - First read from full releases full flag
// - Reads return almost-full, half-full flags high
// - Almost-empty falls again at n words
// - Default empty offset 31, 63, 127
// - Default full offset 31, 63, 127
// - Empty flag low; reads ignored while empty
// - Offset load alternates empty then full offset
package sff_pkg;
   localparam int DATA_W = 18;
   localparam int OFS_W = 12;
   localparam int CMP_W = 14;
   localparam int DEPTH_MIN = 256;
   localparam int DEPTH_MAX = 4096;
   // Fall-through mode is picked by strap {first_load, read_chain, write_chain}
   localparam logic [2:0] STRAP_FT = 3'h1;
   localparam logic [1:0] CFG_SETTLE = 2'h2;
   localparam logic [1:0] FT_LOAD_AT = 2'h2;
   localparam logic [OFS_W-1:0] OFS_256 = 12'h01F;
   localparam logic [OFS_W-1:0] OFS_512 = 12'h03F;
   localparam logic [OFS_W-1:0] OFS_BIG = 12'h07F;

   typedef enum logic [1:0] {
      SFF_CFG = 2'b00,
      SFF_STD = 2'b01,
      SFF_FT = 2'b10
   } sff_mode_t;

   function automatic logic [OFS_W-1:0] sff_def_ofs(input int depth);
      if (depth <= 256) return OFS_256;
      if (depth <= 512) return OFS_512;
      return OFS_BIG;
   endfunction
endpackage

/* logic/sff_ofs_if.sv */
// Carrier for the programmed flag offsets.
// Driven by the offset loader, read by the flag logic.
`timescale 1ns/1ps
interface sff_ofs_if;
   logic [sff_pkg::OFS_W-1:0] empty_ofs;
   logic [sff_pkg::OFS_W-1:0] full_ofs;
   modport src (output empty_ofs, output full_ofs);
   modport snk (input empty_ofs, input full_ofs);
endinterface

/* logic/sff_mem.sv */
// Word store with registered output word.
// Assumes the caller never writes when full nor reads when empty.
`timescale 1ns/1ps
module sff_mem #(
   parameter int DW = sff_pkg::DATA_W,
   parameter int DEPTH = 256
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Write side
   input wire logic wr_en,
   input wire logic [DW-1:0] wdata,
   // Read side
   input wire logic rd_en,
   output logic [DW-1:0] rdata_q
);
   localparam int AW = $clog2(DEPTH);

   logic [DW-1:0] store [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;

   // Pointers wrap by overflow, so depth must be a power of two
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wptr_q <= '0;
      end else if (wr_en) begin
         wptr_q <= wptr_q + AW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wptr_q] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rptr_q <= '0;
         rdata_q <= '0;
      end else if (rd_en) begin
         rptr_q <= rptr_q + AW'(1);
         rdata_q <= store[rptr_q];
      end
   end
endmodule

/* logic/sff_offsets.sv */
// Empty and full offset registers with alternating load.
// Assumes the load and write enables come from same-clock logic.
`timescale 1ns/1ps
module sff_offsets #(
   parameter int DEPTH = 256
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Load controls
   input wire logic wen_n,
   input wire logic offset_load_n,
   input wire logic [sff_pkg::OFS_W-1:0] ofs_data,
   // Offsets out
   sff_ofs_if.src ofs
);
   logic sel_full_q;
   logic [sff_pkg::OFS_W-1:0] empty_q;
   logic [sff_pkg::OFS_W-1:0] full_q;
   logic ld;

   assign ld = !offset_load_n && !wen_n;
   assign ofs.empty_ofs = empty_q;
   assign ofs.full_ofs = full_q;

   // Sequence position survives idle gaps between load bursts
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_full_q <= 1'b0;
         empty_q <= sff_pkg::sff_def_ofs(DEPTH);
         full_q <= sff_pkg::sff_def_ofs(DEPTH);
      end else if (ld) begin
         sel_full_q <= !sel_full_q;
         if (sel_full_q) begin
            full_q <= ofs_data;
         end else begin
            empty_q <= ofs_data;
         end
      end
   end

   a_ofs_alternate: assert property (@(posedge clk) disable iff (!arst_n)
      ld |=> sel_full_q != $past(sel_full_q))
      else $error("offset load did not alternate");
   c_ofs_full_load: cover property (@(posedge clk) disable iff (!arst_n)
      ld && sel_full_q);
endmodule

/* logic/sff_top.sv */
// One 18-bit synchronous FIFO bank: word count, flags and timing mode.
// Assumes writer and reader logic share clk; straps come from pins.
`timescale 1ns/1ps
module sff_top #(
   parameter int DEPTH = 256
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Reset-time straps
   input wire logic first_load_select,
   input wire logic read_chain_in,
   input wire logic write_chain_in,
   // Write side
   input wire logic wen_n,
   input wire logic offset_load_n,
   input wire logic [sff_pkg::DATA_W-1:0] data_in,
   // Read side
   input wire logic ren_n,
   output logic [sff_pkg::DATA_W-1:0] data_out,
   // Status flags
   output logic empty_flag_n,
   output logic almost_empty_flag_n,
   output logic half_full_flag_n,
   output logic almost_full_flag_n,
   output logic full_flag_n,
   output logic fall_through_mode
);
   localparam int CW = $clog2(DEPTH) + 1;
   localparam int XW = sff_pkg::CMP_W;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [XW-1:0] DEPTH_X = XW'(DEPTH);
   localparam logic [XW-1:0] HALF_X = XW'(DEPTH / 2);

   // ******************************************************
   // Parameter check
   // ******************************************************
   // Pointers wrap by overflow, so only powers of two are served
   if (DEPTH < sff_pkg::DEPTH_MIN || DEPTH > sff_pkg::DEPTH_MAX
       || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two from 256 to 4096");
   end

   // ******************************************************
   // Declarations
   // ******************************************************
   sff_ofs_if ofs ();

   sff_pkg::sff_mode_t mode_q;
   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;
   logic [1:0] cfg_cnt_q;
   logic [CW-1:0] mem_cnt_q;
   logic [CW-1:0] mem_cnt_d;
   logic ov_q;
   logic ov_d;
   logic [1:0] ft_dly_q;
   logic wr_ok;
   logic rd_std;
   logic ft_take;
   logic ft_fill;
   logic mem_rd;
   logic empty_d;
   logic ae_d;
   logic hf_d;
   logic af_d;
   logic full_d;
   logic [XW-1:0] cnt_x;

   // ******************************************************
   // Helpers
   // ******************************************************
   sff_mem #(
      .DW(sff_pkg::DATA_W),
      .DEPTH(DEPTH)
   ) u_mem (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(wr_ok),
      .wdata(data_in),
      .rd_en(mem_rd),
      .rdata_q(data_out)
   );

   sff_offsets #(
      .DEPTH(DEPTH)
   ) u_ofs (
      .clk(clk),
      .arst_n(arst_n),
      .wen_n(wen_n),
      .offset_load_n(offset_load_n),
      .ofs_data(data_in[sff_pkg::OFS_W-1:0]),
      .ofs(ofs.src)
   );

   // ******************************************************
   // Timing mode selection
   // ******************************************************
   // Flops cannot load pins under asynchronous reset, so the
   // straps are synchronised and taken once they have settled.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
      end else begin
         strap_s1_q <= {first_load_select, read_chain_in, write_chain_in};
         strap_s2_q <= strap_s1_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_cnt_q <= 2'h0;
      end else if (cfg_cnt_q != sff_pkg::CFG_SETTLE) begin
         cfg_cnt_q <= cfg_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= sff_pkg::SFF_CFG;
      end else begin
         case (mode_q)
            sff_pkg::SFF_CFG: begin
               if (cfg_cnt_q == sff_pkg::CFG_SETTLE) begin
                  if (strap_s2_q == sff_pkg::STRAP_FT) begin
                     mode_q <= sff_pkg::SFF_FT;
                  end else begin
                     mode_q <= sff_pkg::SFF_STD;
                  end
               end
            end
            sff_pkg::SFF_STD: mode_q <= sff_pkg::SFF_STD;
            sff_pkg::SFF_FT: mode_q <= sff_pkg::SFF_FT;
            default: mode_q <= sff_pkg::SFF_CFG;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fall_through_mode <= 1'b0;
      end else begin
         fall_through_mode <= (mode_q == sff_pkg::SFF_FT);
      end
   end

   // ******************************************************
   // Accepted writes and reads
   // ******************************************************
   always_comb begin
      // Writes wait for the mode and stop at full
      wr_ok = (mode_q != sff_pkg::SFF_CFG) && !wen_n && offset_load_n
              && (mem_cnt_q != DEPTH_C);
      // Only an explicit read moves a word out in standard mode
      rd_std = (mode_q == sff_pkg::SFF_STD) && !ren_n
               && (mem_cnt_q != '0);
      ft_take = (mode_q == sff_pkg::SFF_FT) && ov_q && !ren_n;
      ft_fill = (mode_q == sff_pkg::SFF_FT) && (mem_cnt_q != '0)
                && (ov_q ? ft_take : (ft_dly_q == sff_pkg::FT_LOAD_AT));
      mem_rd = rd_std || ft_fill;
   end

   // ******************************************************
   // Fall-through output word
   // ******************************************************
   always_comb begin
      ov_d = ov_q;
      if (ft_fill) begin
         ov_d = 1'b1;
      end else if (ft_take) begin
         ov_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ov_q <= 1'b0;
      end else begin
         ov_q <= ov_d;
      end
   end

   // Counts edges while a word waits and the output word is vacant
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ft_dly_q <= 2'h0;
      end else if (mode_q == sff_pkg::SFF_FT && !ov_q && mem_cnt_q != '0
                   && ft_dly_q != sff_pkg::FT_LOAD_AT) begin
         ft_dly_q <= ft_dly_q + 2'h1;
      end else begin
         ft_dly_q <= 2'h0;
      end
   end

   // ******************************************************
   // Word counter
   // ******************************************************
   // Upstream full and empty guards keep the count within 0 to DEPTH
   always_comb begin
      case ({wr_ok, mem_rd})
         2'b10: mem_cnt_d = mem_cnt_q + CW'(1);
         2'b01: mem_cnt_d = mem_cnt_q - CW'(1);
         default: mem_cnt_d = mem_cnt_q;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_cnt_q <= '0;
      end else begin
         mem_cnt_q <= mem_cnt_d;
      end
   end

   // ******************************************************
   // Flags
   // ******************************************************
   // Computed from the next count (fall-through empty flag: next output-word state) so each
   // flag moves on the same edge as the access or output-word load that causes it.
   always_comb begin
      cnt_x = XW'(mem_cnt_d);
      if (mode_q == sff_pkg::SFF_FT) begin
         empty_d = ov_d;
      end else begin
         empty_d = (mem_cnt_d != '0);
      end
      ae_d = cnt_x > XW'(ofs.empty_ofs);
      hf_d = !(cnt_x > HALF_X);
      af_d = !((cnt_x + XW'(ofs.full_ofs)) >= DEPTH_X);
      full_d = (mem_cnt_d != DEPTH_C);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         empty_flag_n <= 1'b0;
         almost_empty_flag_n <= 1'b0;
         half_full_flag_n <= 1'b1;
         almost_full_flag_n <= 1'b1;
         full_flag_n <= 1'b1;
      end else begin
         empty_flag_n <= empty_d;
         almost_empty_flag_n <= ae_d;
         half_full_flag_n <= hf_d;
         almost_full_flag_n <= af_d;
         full_flag_n <= full_d;
      end
   end

   // ******************************************************
   // Assertions
   // ******************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_count_both: assert property (
      wr_ok && mem_rd |=> mem_cnt_q == $past(mem_cnt_q))
      else $error("count moved on simultaneous write and read");

   a_full_hold: assert property (
      !full_flag_n && !mem_rd |=> $stable(mem_cnt_q) && !full_flag_n)
      else $error("write accepted while full");

   a_full_release: assert property (
      !full_flag_n && rd_std |=> full_flag_n)
      else $error("read from full did not release full flag");

   a_empty_level: assert property (
      mode_q == sff_pkg::SFF_STD |-> empty_flag_n == (mem_cnt_q != '0))
      else $error("empty flag disagrees with count");

   a_empty_ignore: assert property (
      mode_q == sff_pkg::SFF_STD && !empty_flag_n && !ren_n
      |=> $stable(data_out) && !empty_flag_n || mem_cnt_q != '0)
      else $error("read taken while empty");

   a_std_no_show: assert property (
      mode_q == sff_pkg::SFF_STD && ren_n |=> $stable(data_out))
      else $error("output changed without a read");

   a_ft_three: assert property (
      mode_q == sff_pkg::SFF_FT && !ov_q && $rose(mem_cnt_q != '0)
      |-> !ov_q ##1 !ov_q ##1 !ov_q ##1 ov_q)
      else $error("fall-through word not shown after three edges");

   a_half_level: assert property (
      half_full_flag_n == (XW'(mem_cnt_q) <= HALF_X))
      else $error("half-full flag wrong");

   a_ae_level: assert property (
      $stable(ofs.empty_ofs)
      |-> almost_empty_flag_n == (XW'(mem_cnt_q) > XW'(ofs.empty_ofs)))
      else $error("almost-empty flag wrong");

   a_af_level: assert property (
      $stable(ofs.full_ofs) |-> almost_full_flag_n
      == ((XW'(mem_cnt_q) + XW'(ofs.full_ofs)) < DEPTH_X))
      else $error("almost-full flag wrong");

   a_mode_hold: assert property (
      mode_q != sff_pkg::SFF_CFG |=> mode_q == $past(mode_q))
      else $error("timing mode changed after configuration");

   // Pin-level checks: the counter must follow the enables as seen at the pins
   a_write_count: assert property (
      mode_q == sff_pkg::SFF_STD && !wen_n && offset_load_n && full_flag_n && ren_n
      |=> mem_cnt_q == $past(mem_cnt_q) + CW'(1)) else $error("write did not add a word");

   a_read_count: assert property (
      mode_q == sff_pkg::SFF_STD && !ren_n && empty_flag_n && wen_n
      |=> mem_cnt_q == $past(mem_cnt_q) - CW'(1)) else $error("read did not remove a word");

   a_load_no_store: assert property (
      mode_q == sff_pkg::SFF_STD && !offset_load_n && !wen_n && ren_n
      |=> $stable(mem_cnt_q)) else $error("offset load stored a data word");

   a_ft_consume: assert property (
      mode_q == sff_pkg::SFF_FT && empty_flag_n && !ren_n && mem_cnt_q == '0 && wen_n
      |=> !empty_flag_n) else $error("consumed fall-through word still shown");

   a_cfg_idle: assert property (
      mode_q == sff_pkg::SFF_CFG |=> mem_cnt_q == '0)
      else $error("access taken before timing mode was chosen");

   a_count_bound: assert property (
      mem_cnt_q <= DEPTH_C)
      else $error("word count beyond depth");

   a_delay_bound: assert property (
      ft_dly_q <= sff_pkg::FT_LOAD_AT)
      else $error("fall-through delay counter overran");

   a_full_level: assert property (
      full_flag_n == (mem_cnt_q != DEPTH_C))
      else $error("full flag disagrees with count");

   a_af_before_full: assert property (
      !full_flag_n |-> !almost_full_flag_n)
      else $error("full without almost-full");

   a_hf_before_full: assert property (
      !full_flag_n |-> !half_full_flag_n)
      else $error("full without half-full");

   c_full_reached: cover property (!full_flag_n);
   c_ft_show: cover property (mode_q == sff_pkg::SFF_FT && ft_fill && !ov_q);
   c_full_read: cover property (!full_flag_n && rd_std ##1 full_flag_n);
   c_ae_rise: cover property ($rose(almost_empty_flag_n));
endmodule

/* verif/sff_peer.sv */
// Writer and reader logic at the far side of one FIFO bank.
// Assumes one clock shared with the bank; the bench calls its tasks.
`timescale 1ns/1ps
module sff_peer (
   // Clock
   input wire logic clk,
   // Mode straps
   output logic first_load_select,
   output logic read_chain_in,
   output logic write_chain_in,
   // Write and read controls
   output logic wen_n,
   output logic offset_load_n,
   output logic [sff_pkg::DATA_W-1:0] data_in,
   output logic ren_n
);
   initial begin
      {first_load_select, read_chain_in, write_chain_in} = 3'h0;
      wen_n = 1'b1;
      offset_load_n = 1'b1;
      ren_n = 1'b1;
      data_in = 18'h15555;
   end

   // ************************************************
   // Straps: held from before reset until long after capture
   // ************************************************
   task automatic set_mode(input bit ft);
      {first_load_select, read_chain_in, write_chain_in} = ft ? 3'h1 : 3'h0;
   endtask

   // ************************************************
   // Burst of writes, reads, both, or offset loads
   // ************************************************
   task automatic burst(input int len, input bit w, input bit r, input bit ld,
                        input logic [sff_pkg::DATA_W-1:0] base);
      for (int i = 0; i < len; i++) begin
         @(posedge clk);
         #1;
         wen_n = !(w | ld);
         offset_load_n = !ld;
         ren_n = !r;
         data_in = base + 18'(i);
      end
      @(posedge clk);
      #1;
      wen_n = 1'b1;
      offset_load_n = 1'b1;
      ren_n = 1'b1;
      // A released bus must not look like the last word
      data_in = ~data_in;
   endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for one FIFO bank in standard and fall-through mode.
// Assumes the peer model drives all writer and reader inputs.
`timescale 1ns/1ps
module tb_top;
   localparam int DEPTH = 256;
   logic clk;
   logic arst_n;
   logic first_load_select;
   logic read_chain_in;
   logic write_chain_in;
   logic wen_n;
   logic offset_load_n;
   logic [sff_pkg::DATA_W-1:0] data_in;
   logic ren_n;
   logic [sff_pkg::DATA_W-1:0] data_out;
   logic empty_flag_n;
   logic almost_empty_flag_n;
   logic half_full_flag_n;
   logic almost_full_flag_n;
   logic full_flag_n;
   logic fall_through_mode;
   int num_errors;
   int total_checks;
   int cnt;
   int n_ofs;
   int m_ofs;
   int ld_val;
   bit mon_on;
   bit wr;
   bit rd;
   bit ld;
   bit ld_sel;
   logic [sff_pkg::DATA_W-1:0] exp_q[$];
   logic [sff_pkg::DATA_W-1:0] exp_out;

   sff_top #(.DEPTH(DEPTH)) dut (
      .clk(clk), .arst_n(arst_n), .first_load_select(first_load_select),
      .read_chain_in(read_chain_in), .write_chain_in(write_chain_in), .wen_n(wen_n),
      .offset_load_n(offset_load_n), .data_in(data_in), .ren_n(ren_n),
      .data_out(data_out), .empty_flag_n(empty_flag_n),
      .almost_empty_flag_n(almost_empty_flag_n), .half_full_flag_n(half_full_flag_n),
      .almost_full_flag_n(almost_full_flag_n), .full_flag_n(full_flag_n),
      .fall_through_mode(fall_through_mode)
   );

   sff_peer peer (
      .clk(clk), .first_load_select(first_load_select), .read_chain_in(read_chain_in),
      .write_chain_in(write_chain_in), .wen_n(wen_n), .offset_load_n(offset_load_n),
      .data_in(data_in), .ren_n(ren_n)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ************************************************
   // Compare tasks and verdict
   // ************************************************
   task automatic chk_word(input string name, input logic [17:0] e, input logic [17:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chk_flags(input string name, input logic [4:0] e, input logic [4:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b at count %0d", name, e, g, cnt);
      end
   endtask

   task automatic chk_bit(input string name, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", name, e, g);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Order: empty, almost-empty, half-full, almost-full, full
   function automatic logic [4:0] exp_flags(input int c);
      return {c != 0, c > n_ofs, !(c > DEPTH / 2), !(c >= DEPTH - m_ofs), c != DEPTH};
   endfunction

   // ************************************************
   // Standard-mode scoreboard, fed from the inputs only
   // ************************************************
   always @(posedge clk) begin
      if (mon_on) begin
         wr = !wen_n && offset_load_n && cnt < DEPTH;
         rd = !ren_n && cnt > 0;
         ld = !wen_n && !offset_load_n;
         // Offset data is taken at the edge; the bus moves on before the check
         ld_val = int'(data_in[sff_pkg::OFS_W-1:0]);
         if (wr) exp_q.push_back(data_in);
         if (rd) exp_out = exp_q.pop_front();
         cnt = cnt + int'(wr) - int'(rd);
         #2;
         chk_word("data_out", exp_out, data_out);
         chk_flags("flags", exp_flags(cnt), {empty_flag_n, almost_empty_flag_n,
            half_full_flag_n, almost_full_flag_n, full_flag_n});
         // New offsets steer the flags from the following edge on
         if (ld) begin
            if (ld_sel) m_ofs = ld_val;
            else n_ofs = ld_val;
            ld_sel = !ld_sel;
         end
      end
   end

   task automatic do_reset(input bit ft);
      mon_on = 1'b0;
      // Let the last pending scoreboard check finish before reset hits
      if (arst_n === 1'b1) begin
         @(posedge clk);
         #1;
      end
      peer.set_mode(ft);
      arst_n = 1'b0;
      cnt = 0;
      exp_q.delete();
      exp_out = 18'h00000;
      ld_sel = 1'b0;
      n_ofs = int'(sff_pkg::OFS_256);
      m_ofs = int'(sff_pkg::OFS_256);
      repeat (5) @(posedge clk);
      #1;
      chk_word("reset data_out", 18'h00000, data_out);
      chk_flags("reset flags", 5'h07, {empty_flag_n, almost_empty_flag_n,
         half_full_flag_n, almost_full_flag_n, full_flag_n});
      arst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk_bit("fall_through_mode", ft, fall_through_mode);
      mon_on = !ft;
   endtask

   initial begin
      #50000;
      num_errors++;
      stop_test;
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      arst_n = 1'b0;
      num_errors = 0;
      total_checks = 0;
      do_reset(1'b0);
      peer.burst(1, 1'b1, 1'b0, 1'b0, 18'h2A5A5);
      repeat (3) @(posedge clk);
      peer.burst(1, 1'b0, 1'b1, 1'b0, 18'h00000);
      peer.burst(2, 1'b0, 1'b1, 1'b0, 18'h00000);
      // Default offsets, fill past full, then reads while writing at full
      peer.burst(DEPTH + 2, 1'b1, 1'b0, 1'b0, 18'h00100);
      peer.burst(4, 1'b1, 1'b1, 1'b0, 18'h03000);
      peer.burst(DEPTH + 4, 1'b0, 1'b1, 1'b0, 18'h00000);
      // Offsets: empty then full back to back, then a lone empty load
      peer.burst(2, 1'b0, 1'b0, 1'b1, 18'h0000A);
      repeat (2) @(posedge clk);
      peer.burst(1, 1'b0, 1'b0, 1'b1, 18'h00005);
      peer.burst(DEPTH, 1'b1, 1'b0, 1'b0, 18'h02000);
      peer.burst(8, 1'b1, 1'b1, 1'b0, 18'h01000);
      peer.burst(DEPTH + 1, 1'b0, 1'b1, 1'b0, 18'h00000);
      // Fall-through: first word shows three edges after its write
      do_reset(1'b1);
      peer.burst(1, 1'b1, 1'b0, 1'b0, 18'h1C3C3);
      for (int i = 1; i <= 3; i++) begin
         @(posedge clk);
         #2;
         chk_word("ft data_out", (i == 3) ? 18'h1C3C3 : 18'h00000, data_out);
         chk_bit("ft word shown", i == 3, empty_flag_n);
      end
      peer.burst(1, 1'b0, 1'b1, 1'b0, 18'h00000);
      #1;
      chk_bit("ft after consume", 1'b0, empty_flag_n);
      stop_test;
   end
endmodule
